// ---- logic/ats_pkg.sv ----
// constants and types shared by the trigger source select block
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package ats_pkg;
    localparam int AXI_AW = 8;
    localparam int N_PWM_GEN = 5;
    localparam int SEL_W = 5;
    localparam int DIV_W = 7;
    // register byte addresses
    localparam logic [AXI_AW-1:0] ADDR_TRIGSEL0 = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_CORE_CFG = 8'h18;
    localparam logic [AXI_AW-1:0] ADDR_SW_TRIG = 8'h1C;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h20;
    // field positions
    localparam int SEL_LO_LSB = 0;
    localparam int SEL_HI_LSB = 8;
    localparam int DIV_LSB = 0;
    localparam int RES_LSB = 8;
    localparam int EISEL_LSB = 12;
    localparam int SW_COMMON_BIT = 0;
    localparam int SW_LEVEL_BIT = 1;
    localparam int ST_PERIOD_LSB = 0;
    localparam int ST_INVALID_BIT = 8;
    localparam int ST_CLK_BIT = 9;
    // reset values
    localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
    localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
    localparam logic [1:0] RES_RST = 2'h0;
    localparam logic [2:0] EISEL_RST = 3'h0;
    // selector codes
    localparam logic [SEL_W-1:0] CODE_OFF = 5'h00;
    localparam logic [SEL_W-1:0] CODE_SW_COMMON = 5'h01;
    localparam logic [SEL_W-1:0] CODE_SW_LEVEL = 5'h02;
    localparam logic [SEL_W-1:0] CODE_PWM_SEVT = 5'h04;
    localparam logic [SEL_W-1:0] CODE_PWM_PRI1 = 5'h05;
    localparam logic [SEL_W-1:0] CODE_TMR1 = 5'h0C;
    localparam logic [SEL_W-1:0] CODE_TMR2 = 5'h0D;
    localparam logic [SEL_W-1:0] CODE_PWM_SEC_SEVT = 5'h0E;
    localparam logic [SEL_W-1:0] CODE_PWM_SEC1 = 5'h0F;
    localparam logic [SEL_W-1:0] CODE_OC1 = 5'h16;
    localparam logic [SEL_W-1:0] CODE_OC2 = 5'h17;
    localparam logic [SEL_W-1:0] CODE_PWM_CL1 = 5'h18;
    localparam logic [SEL_W-1:0] CODE_EXT = 5'h1F;
    // one bit per reserved code
    localparam logic [31:0] RSV_MASK = 32'h60300C08;
    // clock divider decode
    localparam logic [DIV_W-1:0] DIV_DIRECT_MIN = 7'h02;
    localparam logic [DIV_W-1:0] DIV_MIN_HALF = 7'h01;
    // resolution and early interrupt limits
    localparam logic [1:0] RES_6BIT = 2'h0;
    localparam logic [1:0] RES_8BIT = 2'h1;
    localparam logic [2:0] EISEL_6B_MIN = 3'h4;
    localparam logic [2:0] EISEL_8B_MIN = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // trigger sources as they arrive
    typedef struct packed {
        logic ext;
        logic [N_PWM_GEN-1:0] cl;
        logic oc2;
        logic oc1;
        logic [N_PWM_GEN-1:0] sec;
        logic sevt2;
        logic tmr2;
        logic tmr1;
        logic [N_PWM_GEN-1:0] pri;
        logic sevt;
    } ats_src_t;
endpackage

// ---- logic/ats_trig_if.sv ----
// selector code and start pulse of one analog input slot
// assumes the controller drives the code and the mux drives the start
`timescale 1ns/1ps
`default_nettype none
interface ats_trig_if;
    logic [4:0] code;
    logic start;
    modport ctl (output code, input start);
    modport mux (input code, output start);
endinterface
`default_nettype wire

// ---- logic/ats_trig_mux.sv ----
// trigger routing for one analog input
// assumes src_vec is indexed by selector code and already synchronised
`timescale 1ns/1ps
`default_nettype none
module ats_trig_mux (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] src_vec,
    ats_trig_if.mux trig
);
    logic start_q;
    logic hit;

    // reserved and off codes never pass an event
    assign hit = src_vec[trig.code] && !ats_pkg::RSV_MASK[trig.code]
        && (trig.code != ats_pkg::CODE_OFF);

    // one start request per selected edge event, held every cycle for the level trigger
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= hit;
        end
    end
    assign trig.start = start_q;

    property p_off;
        @(posedge aclk) disable iff (!aresetn)
        trig.code == ats_pkg::CODE_OFF |=> !trig.start;
    endproperty
    a_off: assert property (p_off) else $error("start with trigger off");

    property p_rsv;
        @(posedge aclk) disable iff (!aresetn)
        ats_pkg::RSV_MASK[trig.code] |=> !trig.start;
    endproperty
    a_rsv: assert property (p_rsv) else $error("start from reserved code");

    property p_single;
        @(posedge aclk) disable iff (!aresetn)
        trig.start && trig.code != ats_pkg::CODE_SW_LEVEL
            && $stable(trig.code) |=> !trig.start;
    endproperty
    a_single: assert property (p_single) else $error("edge start longer than one cycle");
endmodule
`default_nettype wire

// ---- logic/ats_core_div.sv ----
// shared converter core clock divider
// assumes the divider code comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module ats_core_div (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [6:0] div_code,
    output logic core_clk,
    output logic [7:0] period
);
    logic [6:0] half;
    logic [6:0] cnt_q;
    logic clk_q;
    logic [7:0] period_q;
    logic clk_prev_q;
    logic [7:0] gap_q;

    // codes 0 and 1 both give two source periods, others give twice the code
    assign half = (div_code < ats_pkg::DIV_DIRECT_MIN) ? ats_pkg::DIV_MIN_HALF : div_code;

    // toggle every half period; a shrinking code ends the phase at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 7'h00;
            clk_q <= 1'b0;
        end else if (cnt_q >= half - 7'h01) begin
            cnt_q <= 7'h00;
            clk_q <= ~clk_q;
        end else begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

    // period in source clocks for status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_q <= 8'h02;
        end else begin
            period_q <= {half, 1'b0};
        end
    end
    assign core_clk = clk_q;
    assign period = period_q;

    // helper: cycles between observed toggles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_prev_q <= 1'b0;
            gap_q <= 8'h00;
        end else begin
            clk_prev_q <= clk_q;
            gap_q <= (clk_q != clk_prev_q) ? 8'h01 : gap_q + 8'h01;
        end
    end

    property p_div3;
        @(posedge aclk) disable iff (!aresetn)
        clk_q != clk_prev_q && div_code == 7'h03 && $past(div_code) == 7'h03
            && $past(div_code, 2) == 7'h03 && $past(div_code, 3) == 7'h03
            |-> gap_q == 8'h03;
    endproperty
    a_div3: assert property (p_div3) else $error("code 3 not six periods");

    property p_div127;
        @(posedge aclk) disable iff (!aresetn)
        div_code == 7'h7F |=> period == 8'hFE;
    endproperty
    a_div127: assert property (p_div127) else $error("code 127 not 254 periods");
endmodule
`default_nettype wire

// ---- logic/ats_top.sv ----
// trigger source select for the converter inputs, with core clock divider
// assumes an AXI4-Lite master on aclk and asynchronous trigger sources
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ats_top #(
    parameter int N_REG = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwm_special_evt,
    input wire logic pwm_sec_special_evt,
    input wire logic [4:0] pwm_primary_trig,
    input wire logic [4:0] pwm_secondary_trig,
    input wire logic [4:0] pwm_current_limit,
    input wire logic timer1_period_match,
    input wire logic timer2_period_match,
    input wire logic oc1_trig,
    input wire logic oc2_trig,
    input wire logic external_trigger_pin,
    output logic [2*N_REG-1:0] conv_start,
    output logic converter_core_clock_period,
    output logic cfg_invalid
);
    logic awready_q, aw_have_q, wready_q, w_have_q, bvalid_q, arready_q, rvalid_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic do_write;
    logic [5:0] widx, ridx;
    logic wr_map, rd_err;
    logic [31:0] rd_word;
    logic [4:0] sel_q [2*N_REG];
    logic [6:0] div_q;
    logic [1:0] res_q;
    logic [2:0] eisel_q;
    logic level_q, common_q, cfg_invalid_q;
    logic [7:0] period;
    logic core_clk;
    ats_pkg::ats_src_t src_raw, src_s1_q, src_s2_q, src_s3_q, src_edge;
    logic [31:0] src_vec;

    assign widx = aw_addr_q[7:2];
    assign ridx = s_axi_araddr[7:2];
    assign do_write = aw_have_q && w_have_q && !bvalid_q;

    // write address channel, taken independently of data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
            awready_q <= 1'b1;
        end else if (!aw_have_q) begin
            awready_q <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_q <= 1'b0;
            wready_q <= 1'b1;
        end else if (!w_have_q) begin
            wready_q <= 1'b1;
        end
    end

    // write decode: every mapped word except status accepts writes
    always_comb begin
        wr_map = (int'(widx) < N_REG) || widx == ats_pkg::ADDR_CORE_CFG[7:2]
            || widx == ats_pkg::ADDR_SW_TRIG[7:2];
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= ats_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? ats_pkg::RESP_OKAY : ats_pkg::RESP_SLVERR;
        end else if (s_axi_bready && bvalid_q) begin
            bvalid_q <= 1'b0;
        end
    end

    // trigger selectors, two five-bit fields per register word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < 2*N_REG; k++) begin
                sel_q[k] <= ats_pkg::SEL_RST;
            end
        end else if (do_write) begin
            for (int x = 0; x < N_REG; x++) begin
                if (int'(widx) == x && w_strb_q[0]) begin
                    sel_q[2*x] <= w_data_q[ats_pkg::SEL_LO_LSB +: ats_pkg::SEL_W];
                end
                if (int'(widx) == x && w_strb_q[1]) begin
                    sel_q[2*x+1] <= w_data_q[ats_pkg::SEL_HI_LSB +: ats_pkg::SEL_W];
                end
            end
        end
    end

    // shared core configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= ats_pkg::DIV_RST;
            res_q <= ats_pkg::RES_RST;
            eisel_q <= ats_pkg::EISEL_RST;
        end else if (do_write && widx == ats_pkg::ADDR_CORE_CFG[7:2]) begin
            if (w_strb_q[0]) begin
                div_q <= w_data_q[ats_pkg::DIV_LSB +: ats_pkg::DIV_W];
            end
            if (w_strb_q[1]) begin
                res_q <= w_data_q[ats_pkg::RES_LSB +: 2];
                eisel_q <= w_data_q[ats_pkg::EISEL_LSB +: 3];
            end
        end
    end

    // software triggers: common is a one-cycle pulse, level is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 1'b0;
            common_q <= 1'b0;
        end else begin
            common_q <= do_write && widx == ats_pkg::ADDR_SW_TRIG[7:2] && w_strb_q[0]
                && w_data_q[ats_pkg::SW_COMMON_BIT];
            if (do_write && widx == ats_pkg::ADDR_SW_TRIG[7:2] && w_strb_q[0]) begin
                level_q <= w_data_q[ats_pkg::SW_LEVEL_BIT];
            end
        end
    end

    // flag early interrupt settings that the resolution cannot use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_invalid_q <= 1'b0;
        end else begin
            cfg_invalid_q <= (res_q == ats_pkg::RES_6BIT && eisel_q >= ats_pkg::EISEL_6B_MIN)
                || (res_q == ats_pkg::RES_8BIT && eisel_q >= ats_pkg::EISEL_8B_MIN);
        end
    end
    assign cfg_invalid = cfg_invalid_q;

    // read decode; unused select bits stay zero
    always_comb begin
        rd_word = 32'h00000000;
        rd_err = 1'b0;
        if (int'(ridx) < N_REG) begin
            rd_word[ats_pkg::SEL_LO_LSB +: ats_pkg::SEL_W] = sel_q[2*int'(ridx)];
            rd_word[ats_pkg::SEL_HI_LSB +: ats_pkg::SEL_W] = sel_q[2*int'(ridx)+1];
        end else if (ridx == ats_pkg::ADDR_CORE_CFG[7:2]) begin
            rd_word[ats_pkg::DIV_LSB +: ats_pkg::DIV_W] = div_q;
            rd_word[ats_pkg::RES_LSB +: 2] = res_q;
            rd_word[ats_pkg::EISEL_LSB +: 3] = eisel_q;
        end else if (ridx == ats_pkg::ADDR_SW_TRIG[7:2]) begin
            rd_word[ats_pkg::SW_LEVEL_BIT] = level_q;
        end else if (ridx == ats_pkg::ADDR_STATUS[7:2]) begin
            rd_word[ats_pkg::ST_PERIOD_LSB +: 8] = period;
            rd_word[ats_pkg::ST_INVALID_BIT] = cfg_invalid_q;
            rd_word[ats_pkg::ST_CLK_BIT] = core_clk;
        end else begin
            rd_err = 1'b1;
        end
    end

    // read channel, one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= ats_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_err ? ats_pkg::RESP_SLVERR : ats_pkg::RESP_OKAY;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // gather raw trigger sources
    always_comb begin
        src_raw.ext = external_trigger_pin;
        src_raw.cl = pwm_current_limit;
        src_raw.oc2 = oc2_trig;
        src_raw.oc1 = oc1_trig;
        src_raw.sec = pwm_secondary_trig;
        src_raw.sevt2 = pwm_sec_special_evt;
        src_raw.tmr2 = timer2_period_match;
        src_raw.tmr1 = timer1_period_match;
        src_raw.pri = pwm_primary_trig;
        src_raw.sevt = pwm_special_evt;
    end

    // two-flop synchroniser plus one stage for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_s1_q <= '0;
            src_s2_q <= '0;
            src_s3_q <= '0;
        end else begin
            src_s1_q <= src_raw;
            src_s2_q <= src_s1_q;
            src_s3_q <= src_s2_q;
        end
    end
    assign src_edge = src_s2_q & ~src_s3_q;

    // event vector indexed by selector code
    always_comb begin
        src_vec = 32'h00000000;
        src_vec[ats_pkg::CODE_SW_COMMON] = common_q;
        src_vec[ats_pkg::CODE_SW_LEVEL] = level_q;
        src_vec[ats_pkg::CODE_PWM_SEVT] = src_edge.sevt;
        src_vec[ats_pkg::CODE_PWM_SEC_SEVT] = src_edge.sevt2;
        for (int g = 0; g < ats_pkg::N_PWM_GEN; g++) begin
            src_vec[int'(ats_pkg::CODE_PWM_PRI1) + g] = src_edge.pri[g];
            src_vec[int'(ats_pkg::CODE_PWM_SEC1) + g] = src_edge.sec[g];
            src_vec[int'(ats_pkg::CODE_PWM_CL1) + g] = src_edge.cl[g];
        end
        src_vec[ats_pkg::CODE_TMR1] = src_edge.tmr1;
        src_vec[ats_pkg::CODE_TMR2] = src_edge.tmr2;
        src_vec[ats_pkg::CODE_OC1] = src_edge.oc1;
        src_vec[ats_pkg::CODE_OC2] = src_edge.oc2;
        src_vec[ats_pkg::CODE_EXT] = src_edge.ext;
    end

    // one router per analog input: register x low field drives slot 2x, high field slot 2x+1
    for (genvar i = 0; i < 2*N_REG; i++) begin : g_slot
        ats_trig_if u_if ();
        assign u_if.code = sel_q[i];
        assign conv_start[i] = u_if.start;
        ats_trig_mux u_mux (
            .aclk(aclk),
            .aresetn(aresetn),
            .src_vec(src_vec),
            .trig(u_if)
        );
    end

    // shared converter core clock
    ats_core_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .div_code(div_q),
        .core_clk(core_clk),
        .period(period)
    );
    assign converter_core_clock_period = core_clk;

    property p_rd_rsv;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && arready_q && int'(ridx) < N_REG
            |=> rdata_q[15:13] == 3'h0 && rdata_q[7:5] == 3'h0 && rdata_q[31:16] == 16'h0000;
    endproperty
    a_rd_rsv: assert property (p_rd_rsv) else $error("reserved select bits not zero");

    property p_rst;
        @(posedge aclk) !aresetn |=> sel_q[0] == 5'h00 && sel_q[1] == 5'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("selector not cleared by reset");

    property p_sevt;
        @(posedge aclk) disable iff (!aresetn)
        $rose(src_s2_q.sevt) && sel_q[0] == 5'h04 |=> conv_start[0];
    endproperty
    a_sevt: assert property (p_sevt) else $error("special event not routed");

    property p_pri;
        @(posedge aclk) disable iff (!aresetn)
        $rose(src_s2_q.pri[0]) && sel_q[0] == 5'h05 |=> conv_start[0];
    endproperty
    a_pri: assert property (p_pri) else $error("primary trigger 1 not routed");

    property p_sec;
        @(posedge aclk) disable iff (!aresetn)
        $rose(src_s2_q.sec[4]) && sel_q[1] == 5'h13 |=> conv_start[1];
    endproperty
    a_sec: assert property (p_sec) else $error("secondary trigger 5 not routed");

    property p_tmr;
        @(posedge aclk) disable iff (!aresetn)
        $rose(src_s2_q.tmr2) && sel_q[0] == 5'h0D |=> conv_start[0];
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer 2 match not routed");

    property p_oc;
        @(posedge aclk) disable iff (!aresetn)
        $rose(src_s2_q.oc1) && sel_q[1] == 5'h16 |=> conv_start[1];
    endproperty
    a_oc: assert property (p_oc) else $error("compare 1 not routed");

    property p_ext;
        @(posedge aclk) disable iff (!aresetn)
        $rose(external_trigger_pin) && sel_q[1] == 5'h1F && $stable(sel_q[1])
            ##1 sel_q[1] == 5'h1F ##1 sel_q[1] == 5'h1F |-> ##[1:2] conv_start[1];
    endproperty
    a_ext: assert property (p_ext) else $error("external pin not routed");

    property p_cfg;
        @(posedge aclk) disable iff (!aresetn)
        res_q == 2'h1 && eisel_q == 3'h6 |=> cfg_invalid;
    endproperty
    a_cfg: assert property (p_cfg) else $error("invalid setting not flagged");
endmodule
`default_nettype wire

// ---- verification/ats_src_model.sv ----
// trigger source model: pulses one on-chip event per request
// assumes fire is raised for one clock together with a selector code
`timescale 1ns/1ps
`default_nettype none
module ats_src_model (
    input wire logic aclk,
    input wire logic [4:0] code,
    input wire logic fire,
    output logic [31:0] ev
);
    // one-hot event by code, low next cycle so each pulse is a single edge
    always_ff @(posedge aclk) begin
        ev <= fire ? (32'h00000001 << code) : 32'h00000000;
    end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the trigger source select block
// assumes the source model feeds every hardware trigger input
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] ROUTED = 32'h9FCFF3F2;
    localparam logic [6:0] DIVS [5] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h7F};
    localparam logic [7:0] PERS [5] = '{8'h02, 8'h02, 8'h04, 8'h06, 8'hFE};
    localparam logic [5:0] EIS [4] = '{6'h24, 6'h03, 6'h2E, 6'h0D};
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire, cclk, inv;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, ev, d;
    logic [3:0] wstrb;
    logic [4:0] code;
    logic [11:0] cs;
    int mismatches, n_compared, n;
    ats_src_model src (.aclk(aclk), .code(code), .fire(fire), .ev(ev));
    ats_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm_special_evt(ev[4]), .pwm_sec_special_evt(ev[14]), .pwm_primary_trig(ev[9:5]),
        .pwm_secondary_trig(ev[19:15]), .pwm_current_limit(ev[28:24]),
        .timer1_period_match(ev[12]), .timer2_period_match(ev[13]), .oc1_trig(ev[22]),
        .oc2_trig(ev[23]), .external_trigger_pin(ev[31]), .conv_start(cs),
        .converter_core_clock_period(cclk), .cfg_invalid(inv));
    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] e);
        logic pa, pw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && awready === 1'b1) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wready === 1'b1) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        e = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        v = rdata;
        e = rresp;
        rready <= 1'b0;
    endtask
    // program one selector, fire its source, count starts on that input only
    task automatic run(input int x, input int hi, input logic [4:0] c);
        wr(ats_pkg::ADDR_TRIGSEL0 + 8'(4 * x), 32'(c) << (8 * hi), r);
        n = 0;
        fork
            repeat (12) begin
                @(posedge aclk);
                if (cs[2 * x + hi] === 1'b1) n++;
                if ((cs & ~(12'h001 << (2 * x + hi))) !== 12'h000) n += 100;
            end
            if (c == ats_pkg::CODE_SW_COMMON) wr(ats_pkg::ADDR_SW_TRIG, 32'h00000001, r);
            else begin
                @(posedge aclk);
                code <= c;
                fire <= 1'b1;
                @(posedge aclk);
                fire <= 1'b0;
            end
        join
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        code = 5'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ats_pkg::ADDR_TRIGSEL0, d, r);
        chk("sel reset", 32'h00000000, d);
        wr(ats_pkg::ADDR_TRIGSEL0 + 8'h04, 32'hFFFFFFFF, r);
        chk("write resp", 32'(ats_pkg::RESP_OKAY), 32'(r));
        rd(ats_pkg::ADDR_TRIGSEL0 + 8'h04, d, r);
        chk("sel bits", 32'h00001F1F, d);
        // park register 1 at off so its inputs stay quiet in the routing tests
        wr(ats_pkg::ADDR_TRIGSEL0 + 8'h04, 32'h00000000, r);
        wr(ats_pkg::ADDR_STATUS, 32'h00000000, r);
        chk("status write resp", 32'(ats_pkg::RESP_SLVERR), 32'(r));
        rd(8'h24, d, r);
        chk("unmapped resp", 32'(ats_pkg::RESP_SLVERR), 32'(r));
        $display("test registers done");
        for (int c = 0; c < 32; c++) begin
            run(0, 0, 5'(c));
            chk("start count", 32'(ROUTED[c]), n);
        end
        run(0, 1, 5'h13);
        chk("high start", 32'h00000001, n);
        run(0, 1, ats_pkg::CODE_OC1);
        chk("high start", 32'h00000001, n);
        run(0, 1, ats_pkg::CODE_EXT);
        chk("high start", 32'h00000001, n);
        // register 0 back to off before other slots use the external pin
        wr(ats_pkg::ADDR_TRIGSEL0, 32'h00000000, r);
        run(5, 1, ats_pkg::CODE_EXT);
        chk("high start", 32'h00000001, n);
        run(2, 1, ats_pkg::CODE_TMR2);
        chk("high start", 32'h00000001, n);
        // level software trigger holds the start while its bit is set
        wr(ats_pkg::ADDR_TRIGSEL0, 32'(ats_pkg::CODE_SW_LEVEL), r);
        wr(ats_pkg::ADDR_SW_TRIG, 32'h00000002, r);
        repeat (2) @(posedge aclk);
        chk("level start", 32'h00000001, 32'(cs[0]));
        rd(ats_pkg::ADDR_SW_TRIG, d, r);
        chk("level bit", 32'h00000002, d);
        wr(ats_pkg::ADDR_SW_TRIG, 32'h00000000, r);
        repeat (2) @(posedge aclk);
        chk("level stop", 32'h00000000, 32'(cs[0]));
        $display("test triggers done");
        foreach (DIVS[i]) begin
            wr(ats_pkg::ADDR_CORE_CFG, {25'h0, DIVS[i]}, r);
            rd(ats_pkg::ADDR_STATUS, d, r);
            chk("core period", {24'h0, PERS[i]}, {24'h0, d[7:0]});
        end
        // code 3 is six source clocks: four toggles in any twelve edges
        wr(ats_pkg::ADDR_CORE_CFG, 32'h00000003, r);
        repeat (4) @(posedge aclk);
        n = 0;
        d[0] = cclk;
        repeat (12) begin
            @(posedge aclk);
            if (cclk !== d[0]) n++;
            d[0] = cclk;
        end
        chk("core clock toggles", 32'h00000004, n);
        foreach (EIS[i]) begin
            wr(ats_pkg::ADDR_CORE_CFG, {17'h0, EIS[i][2:0], 2'h0, EIS[i][4:3], 8'h00}, r);
            @(posedge aclk);
            chk("cfg invalid", 32'(EIS[i][5]), 32'(inv));
        end
        $display("test core config done");
        end_sim();
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
